// ---- common/dhm_buf_if.sv ----
// valid/ready carrier around the host write buffer
interface dhm_buf_if;
  import dhm_pkg::*;
  logic     in_valid;
  logic     in_ready;
  dhm_hwr_t in_data;
  logic     out_valid;
  logic     out_ready;
  dhm_hwr_t out_data;

  modport buffer (
    input  in_valid,
    output in_ready,
    input  in_data,
    output out_valid,
    input  out_ready,
    output out_data
  );

  modport user (
    output in_valid,
    input  in_ready,
    output in_data,
    input  out_valid,
    output out_ready,
    input  out_data
  );
endinterface

// ---- common/dhm_pkg.sv ----
// types shared by the host mailbox port modules
package dhm_pkg;

  // host access tracker
  typedef enum logic [1:0] {
    DHM_IDLE,
    DHM_READ,
    DHM_WRITE
  } dhm_hst_t;

  // one committed host write
  typedef struct packed {
    logic       pm;
    logic       cmd;
    logic [7:0] data;
  } dhm_hwr_t;

endpackage

// ---- common/dhm_regs.svh ----
// register map, status fields, reset values and address bit meaning of the host mailbox port
`ifndef DHM_REGS_SVH
`define DHM_REGS_SVH

// local core register addresses
`define DHM_KB_STAT_ADDR 8'hAD
`define DHM_KB_DIN_ADDR  8'hAE
`define DHM_KB_DOUT_ADDR 8'hAF
`define DHM_PM_STAT_ADDR 8'hBD
`define DHM_PM_DIN_ADDR  8'hBE
`define DHM_PM_DOUT_ADDR 8'hBF

// status field positions
`define DHM_OBF_BIT 0
`define DHM_IBF_BIT 1
`define DHM_CD_BIT  3

// user status bits 7..4 and 2
`define DHM_USR_MASK 8'hF4

// flag reset value, answer for an unmapped read
`define DHM_FLAG_RESET 1'b0
`define DHM_UNMAPPED   8'h00

// host address bit meaning
`define DHM_A0_DATA 1'b0
`define DHM_A0_STAT 1'b1

`endif

// ---- rtl/dhm_buf.sv ----
// two-entry buffer for committed host writes
module dhm_buf (
  input wire logic ref_clk, // core clock
  input wire logic srst,    // sync reset, active high
  dhm_buf_if.buffer bus     // fill and drain sides
);
  import dhm_pkg::*;

  dhm_hwr_t   mem_q [2];
  logic       wp_q;
  logic       rp_q;
  logic [1:0] cnt_q;
  logic       push;
  logic       pop;

  assign bus.in_ready  = (cnt_q != 2'd2);
  assign bus.out_valid = (cnt_q != 2'd0);
  assign bus.out_data  = mem_q[rp_q];
  assign push          = bus.in_valid & bus.in_ready;
  assign pop           = bus.out_valid & bus.out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= bus.in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= 2'd0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 2'd1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 2'd1;
    end
  end
endmodule

// ---- rtl/dhm_port.sv ----
// dual host mailbox port: keyboard and power ports between host bus and core
//
// Contract
// - keyboard select, address 0 reads output data; address 1 reads status.
// - keyboard write at address 0 loads input data, command flag cleared.
// - keyboard write at address 1 loads input data, command flag set.
// - power port decodes the same way with its own registers.
// - both selects high ignores the bus; both low is undefined.
// - three core registers per port, two host locations.
// - core addresses AD/AE/AF and BD/BE/BF; status writable on user bits.
// - input data is read-only to core, write-only to host.
// - host write to input data sets input-full flag.
// - core read of input data clears input-full; reset clears it.
// - input-full drives per-port core interrupt when its enable is set.
// - status bit 3 command, bit 1 input-full, bit 0 output-full.
// - user status bits are core storage, host read-only, reset untouched.
// - command flag read-only, changes only on host writes, no reset.
// - input data registers keep contents over reset, no initial value.
// - core write of output data sets output-full; host read clears it.
// - keyboard output-full drives high host irq, power drives low irq.
`include "dhm_regs.svh"

module dhm_port (
  input  wire logic       ref_clk,                    // core clock, 25 MHz
  input  wire logic       srst,                       // sync reset, active high
  input  wire logic       keyboard_port_select_n,     // host keyboard select
  input  wire logic       power_port_select_n,        // host power select
  input  wire logic       host_addr_bit,              // host address bit
  input  wire logic       host_read_strobe_n,         // host read strobe
  input  wire logic       host_write_strobe_n,        // host write strobe
  input  wire logic [7:0] host_data_in,               // host data bus in
  output logic      [7:0] host_data_out,              // host data bus out
  output logic            host_data_oe,               // host data drive enable
  output logic            host_keyboard_irq,          // keyboard data waiting
  output logic            host_power_irq_n,           // power data waiting
  input  wire logic [7:0] sfr_addr,                   // core register address
  input  wire logic       sfr_wr,                     // core write strobe
  input  wire logic       sfr_rd,                     // core read strobe
  input  wire logic [7:0] sfr_wdata,                  // core write data
  output logic      [7:0] sfr_rdata,                  // core read data
  input  wire logic       keyboard_buffer_irq_enable, // keyboard irq enable
  input  wire logic       power_buffer_irq_enable,    // power irq enable
  output logic            keyboard_buffer_irq,        // keyboard input full irq
  output logic            power_buffer_irq            // power input full irq
);
  import dhm_pkg::*;

  // synchroniser stages
  logic [3:0] sy1_q;
  logic [3:0] sy2_q;
  logic       ksel_s;
  logic       psel_s;
  logic       rd_s;
  logic       wr_s;

  // host access tracker
  dhm_hst_t   hst_q;
  dhm_hst_t   hst_d;
  logic       acc_pm_q;
  logic       acc_a0_q;
  logic [7:0] cap_q;
  dhm_hwr_t   pend_q;
  logic       pend_vld_q;
  logic       sel_ok;
  logic       rd_done;
  logic       wr_done;

  // per-port state
  logic [7:0] din_q  [2];
  logic [7:0] dout_q [2];
  logic [7:0] usr_q  [2];
  logic       cd_q   [2];
  logic       ibf_q  [2];
  logic       obf_q  [2];
  logic       ibf_d  [2];
  logic       obf_d  [2];
  logic [7:0] stat   [2];
  logic       din_rd [2];
  logic       irq_en [2];

  // output flops
  logic [7:0] hdo_q;
  logic       hoe_q;
  logic       kirq_q;
  logic       pirq_n_q;
  logic [7:0] rdata_q;
  logic       kbi_q;
  logic       pbi_q;

  // buffer hookup
  dhm_buf_if  bif ();
  logic       drain;
  logic       core_din_rd;

  always_ff @(posedge ref_clk) begin
    sy1_q <= {keyboard_port_select_n, power_port_select_n,
              host_read_strobe_n, host_write_strobe_n};
    sy2_q <= sy1_q;
  end

  assign ksel_s = sy2_q[3];
  assign psel_s = sy2_q[2];
  assign rd_s   = sy2_q[1];
  assign wr_s   = sy2_q[0];

  // exactly one select low, else bus ignored
  assign sel_ok = ksel_s ^ psel_s;

  assign rd_done = (hst_q == DHM_READ) && rd_s;
  assign wr_done = (hst_q == DHM_WRITE) && wr_s && !pend_vld_q;

  always_comb begin
    hst_d = hst_q;
    case (hst_q)
      DHM_IDLE: begin
        if (sel_ok && !rd_s && wr_s) begin
          hst_d = DHM_READ;
        end else if (sel_ok && !wr_s && rd_s) begin
          hst_d = DHM_WRITE;
        end
      end
      DHM_READ: begin
        if (rd_s) begin
          hst_d = DHM_IDLE;
        end
      end
      DHM_WRITE: begin
        if (wr_done) begin
          hst_d = DHM_IDLE;
        end
      end
      default: begin
        hst_d = DHM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hst_q <= DHM_IDLE;
    end else begin
      hst_q <= hst_d;
    end
  end

  // latch port and address at strobe start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_pm_q <= 1'b0;
      acc_a0_q <= 1'b0;
    end else if (hst_q == DHM_IDLE && hst_d != DHM_IDLE) begin
      acc_pm_q <= ksel_s;
      acc_a0_q <= host_addr_bit;
    end
  end

  // data is taken once, as the write strobe is seen
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cap_q <= 8'h00;
    end else if (hst_q == DHM_IDLE && hst_d == DHM_WRITE) begin
      cap_q <= host_data_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_vld_q <= 1'b0;
      pend_q     <= '0;
    end else if (wr_done) begin
      pend_vld_q <= 1'b1;
      pend_q     <= '{pm: acc_pm_q, cmd: acc_a0_q, data: cap_q};
    end else if (bif.in_ready) begin
      pend_vld_q <= 1'b0;
    end
  end

  // core reading an input data register holds off the drain
  assign core_din_rd = sfr_rd && (sfr_addr == `DHM_KB_DIN_ADDR ||
                                  sfr_addr == `DHM_PM_DIN_ADDR);

  assign bif.in_valid  = pend_vld_q;
  assign bif.in_data   = pend_q;
  assign bif.out_ready = !core_din_rd;
  assign drain         = bif.out_valid && bif.out_ready;

  dhm_buf u_buf (
    .ref_clk (ref_clk),
    .srst    (srst),
    .bus     (bif.buffer)
  );

  assign irq_en[0] = keyboard_buffer_irq_enable;
  assign irq_en[1] = power_buffer_irq_enable;

  // both ports built from one description
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam logic [7:0] A_ST  = p ? `DHM_PM_STAT_ADDR : `DHM_KB_STAT_ADDR;
    localparam logic [7:0] A_DIN = p ? `DHM_PM_DIN_ADDR : `DHM_KB_DIN_ADDR;
    localparam logic [7:0] A_DO  = p ? `DHM_PM_DOUT_ADDR : `DHM_KB_DOUT_ADDR;
    localparam logic       PM    = p ? 1'b1 : 1'b0;

    logic wr_in;
    logic ho_rd;

    assign wr_in     = drain && (bif.out_data.pm == PM);
    assign din_rd[p] = sfr_rd && (sfr_addr == A_DIN);
    assign ho_rd     = rd_done && (acc_pm_q == PM) && (acc_a0_q == `DHM_A0_DATA);

    always_comb begin
      stat[p]             = usr_q[p] & `DHM_USR_MASK;
      stat[p][`DHM_CD_BIT]  = cd_q[p];
      stat[p][`DHM_IBF_BIT] = ibf_q[p];
      stat[p][`DHM_OBF_BIT] = obf_q[p];
    end

    always_ff @(posedge ref_clk) begin
      if (wr_in) begin
        din_q[p] <= bif.out_data.data;
      end
    end

    // command flag from host writes only
    always_ff @(posedge ref_clk) begin
      if (wr_in) begin
        cd_q[p] <= bif.out_data.cmd;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sfr_wr && sfr_addr == A_ST) begin
        usr_q[p] <= sfr_wdata & `DHM_USR_MASK;
      end
    end

    // output data, unaffected by reset
    always_ff @(posedge ref_clk) begin
      if (sfr_wr && sfr_addr == A_DO) begin
        dout_q[p] <= sfr_wdata;
      end
    end

    always_comb begin
      ibf_d[p] = ibf_q[p];
      if (din_rd[p]) begin
        ibf_d[p] = 1'b0;
      end
      if (wr_in) begin
        ibf_d[p] = 1'b1;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        ibf_q[p] <= `DHM_FLAG_RESET;
      end else begin
        ibf_q[p] <= ibf_d[p];
      end
    end

    // core write sets, host read clears
    always_comb begin
      obf_d[p] = obf_q[p];
      if (ho_rd) begin
        obf_d[p] = 1'b0;
      end
      if (sfr_wr && sfr_addr == A_DO) begin
        obf_d[p] = 1'b1;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        obf_q[p] <= `DHM_FLAG_RESET;
      end else begin
        obf_q[p] <= obf_d[p];
      end
    end
  end

  // host read data, reloaded every cycle of the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hdo_q <= 8'h00;
    end else if (hst_d == DHM_READ) begin
      hdo_q <= (host_addr_bit == `DHM_A0_STAT && hst_q == DHM_IDLE) ||
               (acc_a0_q == `DHM_A0_STAT && hst_q == DHM_READ)
               ? stat[hst_q == DHM_IDLE ? ksel_s : acc_pm_q]
               : dout_q[hst_q == DHM_IDLE ? ksel_s : acc_pm_q];
    end
  end

  // drive only during a valid read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hoe_q <= 1'b0;
    end else begin
      hoe_q <= (hst_d == DHM_READ);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      kirq_q   <= 1'b0;
      pirq_n_q <= 1'b1;
    end else begin
      kirq_q   <= obf_d[0];
      pirq_n_q <= ~obf_d[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      kbi_q <= 1'b0;
      pbi_q <= 1'b0;
    end else begin
      kbi_q <= ibf_d[0] & irq_en[0];
      pbi_q <= ibf_d[1] & irq_en[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= `DHM_UNMAPPED;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `DHM_KB_STAT_ADDR: rdata_q <= stat[0];
        `DHM_KB_DIN_ADDR:  rdata_q <= din_q[0];
        `DHM_KB_DOUT_ADDR: rdata_q <= dout_q[0];
        `DHM_PM_STAT_ADDR: rdata_q <= stat[1];
        `DHM_PM_DIN_ADDR:  rdata_q <= din_q[1];
        `DHM_PM_DOUT_ADDR: rdata_q <= dout_q[1];
        default:           rdata_q <= `DHM_UNMAPPED;
      endcase
    end
  end

  // no core write path into input data
  assign sfr_rdata           = rdata_q;
  assign host_data_out       = hdo_q;
  assign host_data_oe        = hoe_q;
  assign host_keyboard_irq   = kirq_q;
  assign host_power_irq_n    = pirq_n_q;
  assign keyboard_buffer_irq = kbi_q;
  assign power_buffer_irq    = pbi_q;
endmodule

// ---- test/dhm_host_model.sv ----
// host processor model on the parallel port bus
module dhm_host_model (
  input  wire logic       ref_clk,                // pacing clock
  output logic            keyboard_port_select_n, // keyboard select
  output logic            power_port_select_n,    // power select
  output logic            host_addr_bit,          // address bit
  output logic            host_read_strobe_n,     // read strobe
  output logic            host_write_strobe_n,    // write strobe
  output logic      [7:0] host_data_in,           // write data
  input  wire logic [7:0] host_data_out,          // read data
  input  wire logic       host_data_oe            // device drives bus
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    keyboard_port_select_n = 1'b1;
    power_port_select_n = 1'b1;
    host_addr_bit = 1'b0;
    host_read_strobe_n = 1'b1;
    host_write_strobe_n = 1'b1;
    host_data_in = 8'h00;
  end
  // sel 0 keyboard, 1 power, 2 none; n cycles of strobe
  task automatic access(input logic [1:0] sel, input logic a0, input logic wr, input logic [7:0] wd,
                        input int n, output logic [7:0] rd);
    @(negedge ref_clk);
    keyboard_port_select_n = (sel != 2'd0);
    power_port_select_n = (sel != 2'd1);
    host_addr_bit = a0;
    host_data_in = wd;
    host_read_strobe_n = wr;
    host_write_strobe_n = !wr;
    repeat (n) @(negedge ref_clk);
    rd = host_data_oe ? host_data_out : 8'hxx;
    host_read_strobe_n = 1'b1;
    host_write_strobe_n = 1'b1;
    keyboard_port_select_n = 1'b1;
    power_port_select_n = 1'b1;
    host_data_in = ~wd;
    repeat (5) @(negedge ref_clk);
  endtask
endmodule

// ---- test/dhm_port_properties.sv ----
// concurrent checks on the host mailbox port pins
`include "dhm_regs.svh"
module dhm_port_properties (
  input wire logic       ref_clk,                    // core clock
  input wire logic       srst,                       // sync reset
  input wire logic       keyboard_port_select_n,     // keyboard select
  input wire logic       power_port_select_n,        // power select
  input wire logic       host_addr_bit,              // address bit
  input wire logic       host_read_strobe_n,         // read strobe
  input wire logic       host_data_oe,               // bus drive
  input wire logic       host_keyboard_irq,          // keyboard host irq
  input wire logic       host_power_irq_n,           // power host irq
  input wire logic [7:0] sfr_addr,                   // core address
  input wire logic       sfr_wr,                     // core write
  input wire logic       sfr_rd,                     // core read
  input wire logic       keyboard_buffer_irq_enable, // keyboard enable
  input wire logic       power_buffer_irq_enable,    // power enable
  input wire logic       keyboard_buffer_irq,        // keyboard core irq
  input wire logic       power_buffer_irq            // power core irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  sequence s_kb_out_wr;
    sfr_wr && sfr_addr == `DHM_KB_DOUT_ADDR;
  endsequence
  sequence s_pm_out_wr;
    sfr_wr && sfr_addr == `DHM_PM_DOUT_ADDR;
  endsequence
  sequence s_rd_idle;
    host_read_strobe_n [*5];
  endsequence
  property p_kb_irq_set;
    s_kb_out_wr |-> ##[1:2] host_keyboard_irq;
  endproperty
  property p_pm_irq_set;
    s_pm_out_wr |-> ##[1:2] !host_power_irq_n;
  endproperty
  property p_kb_irq_clr;
    $fell(host_keyboard_irq) |-> $past(!host_read_strobe_n && !keyboard_port_select_n && !host_addr_bit, 5);
  endproperty
  property p_pm_irq_clr;
    $rose(host_power_irq_n) |-> $past(!host_read_strobe_n && !power_port_select_n && !host_addr_bit, 5);
  endproperty
  property p_oe_cause;
    $rose(host_data_oe) |-> $past(!host_read_strobe_n && (keyboard_port_select_n != power_port_select_n), 2);
  endproperty
  property p_oe_end;
    s_rd_idle |-> !host_data_oe;
  endproperty
  property p_kb_en;
    !keyboard_buffer_irq_enable |=> !keyboard_buffer_irq;
  endproperty
  property p_pm_en;
    !power_buffer_irq_enable |=> !power_buffer_irq;
  endproperty
  property p_kb_din_rd;
    sfr_rd && sfr_addr == `DHM_KB_DIN_ADDR |=> !keyboard_buffer_irq;
  endproperty
  a_kb_irq_set: assert property (p_kb_irq_set)
    else $error("keyboard host irq not raised");
  a_pm_irq_set: assert property (p_pm_irq_set)
    else $error("power host irq not raised");
  a_kb_irq_clr: assert property (p_kb_irq_clr)
    else $error("keyboard host irq dropped without read");
  a_pm_irq_clr: assert property (p_pm_irq_clr)
    else $error("power host irq dropped without read");
  a_oe_cause: assert property (p_oe_cause)
    else $error("bus driven without selected read");
  a_oe_end: assert property (p_oe_end)
    else $error("bus still driven after read");
  a_kb_en: assert property (p_kb_en)
    else $error("keyboard core irq while disabled");
  a_pm_en: assert property (p_pm_en)
    else $error("power core irq while disabled");
  a_kb_din_rd: assert property (p_kb_din_rd)
    else $error("keyboard core irq after data read");
endmodule

bind dhm_port dhm_port_properties dhm_port_properties_inst (.*);

// ---- test/testbench.sv ----
// self-checking bench for the host mailbox port
`include "dhm_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, srst, host_data_oe, host_keyboard_irq, host_power_irq_n;
  logic       keyboard_port_select_n, power_port_select_n, host_addr_bit;
  logic       host_read_strobe_n, host_write_strobe_n, sfr_wr, sfr_rd;
  logic       keyboard_buffer_irq_enable, power_buffer_irq_enable, keyboard_buffer_irq, power_buffer_irq;
  logic [7:0] host_data_in, host_data_out, sfr_addr, sfr_wdata, sfr_rdata, r, h;
  logic [7:0] usr [2];
  logic [7:0] d [2];
  logic       cd [2];
  logic [1:0] en;
  int         fail_count, cmp_count;

  dhm_port dhm_port_inst (.*);
  dhm_host_model dhm_host_model_inst (.*);

  function automatic logic [7:0] adr(input int p, input int k);
    return (p != 0 ? `DHM_PM_STAT_ADDR : `DHM_KB_STAT_ADDR) + 8'(k);
  endfunction
  function automatic logic [7:0] stat(input logic [7:0] u, input logic c, input logic i, input logic o);
    return {u[7:4], c, u[2], i, o};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic sw(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic sr(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #(40 * 5000);
    fail_count++;
    test_done();
  end
  initial begin
    fail_count = 0;
    cmp_count = 0;
    srst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    keyboard_buffer_irq_enable = 1'b0;
    power_buffer_irq_enable = 1'b0;
    r = 8'($urandom(5));
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    for (int p = 0; p < 2; p++) begin
      sr(adr(p, 0), r);
      chk(r & 8'h03, 8'h00);
    end
    chkb(host_keyboard_irq, 1'b0);
    chkb(host_power_irq_n, 1'b1);
    for (int a = 0; a < 2; a++) begin
      // second pass flips enables so both levels reach each port
      en = a[0] ? ~en : 2'($urandom);
      keyboard_buffer_irq_enable = en[0];
      power_buffer_irq_enable = en[1];
      for (int p = 0; p < 2; p++) begin
        d[p] = 8'($urandom);
        cd[p] = a[0];
        dhm_host_model_inst.access(2'(p), a[0], 1'b1, d[p], 3 + $urandom % 3, h);
      end
      repeat (4) @(negedge ref_clk);
      for (int p = 0; p < 2; p++) begin
        sr(adr(p, 0), r);
        chk(r & 8'h0B, stat(8'h00, a[0], 1'b1, 1'b0));
        chkb(p != 0 ? power_buffer_irq : keyboard_buffer_irq, en[p]);
        sw(adr(p, 1), ~d[p]);
        sr(adr(p, 1), r);
        chk(r, d[p]);
        sr(adr(p, 0), r);
        chk(r & 8'h02, 8'h00);
        chkb(p != 0 ? power_buffer_irq : keyboard_buffer_irq, 1'b0);
      end
    end
    dhm_host_model_inst.access(2'd2, 1'b0, 1'b1, 8'h5A, 4, h);
    for (int p = 0; p < 2; p++) begin
      usr[p] = 8'($urandom);
      sw(adr(p, 0), usr[p]);
      sr(adr(p, 0), r);
      chk(r, stat(usr[p], cd[p], 1'b0, 1'b0));
      dhm_host_model_inst.access(2'(p), 1'b1, 1'b0, 8'h00, 4, h);
      chk(h, stat(usr[p], cd[p], 1'b0, 1'b0));
      d[p] = 8'($urandom);
      sw(adr(p, 2), d[p]);
      @(negedge ref_clk);
      chkb(p != 0 ? !host_power_irq_n : host_keyboard_irq, 1'b1);
      sr(adr(p, 2), r);
      chk(r, d[p]);
      sr(adr(p, 0), r);
      chk(r, stat(usr[p], cd[p], 1'b0, 1'b1));
      dhm_host_model_inst.access(2'(p), 1'b0, 1'b0, 8'h00, 4 + $urandom % 3, h);
      chk(h, d[p]);
      chkb(p != 0 ? !host_power_irq_n : host_keyboard_irq, 1'b0);
    end
    d[0] = 8'($urandom);
    cd[0] = 1'b0;
    dhm_host_model_inst.access(2'd0, 1'b0, 1'b1, d[0], 4, h);
    sw(adr(1, 2), d[1]);
    srst = 1'b1;
    repeat (3) @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chkb(host_power_irq_n, 1'b1);
    for (int p = 0; p < 2; p++) begin
      sr(adr(p, 0), r);
      chk(r, stat(usr[p], cd[p], 1'b0, 1'b0));
    end
    sr(adr(0, 1), r);
    chk(r, d[0]);
    sr(8'hAC, r);
    chk(r, `DHM_UNMAPPED);
    test_done();
  end
endmodule
